// ===== include/port_cfg.svh
// constants for the port configuration block
//
// Contract
// - mode selector resets to direction select
// - mode value steers each configuration write
// - modes 09/08 swap working value, port B
// - direction bit 1 input, 0 output
// - all pins inputs after reset
// - direction writable any time, repeatedly
// - pull-up bit 1 off, 0 on
// - pull-ups off after reset
// - pull-up writable always, effective as input
// - ports C, D, E exist per variant
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

`define MODE_DIR 4'hF
`define MODE_PULL 4'hE
`define MODE_LVL 4'hD
`define MODE_ST 4'hC
`define MODE_WKEN 4'hB
`define MODE_WKED 4'hA
`define MODE_PEND 4'h9
`define MODE_COMP 4'h8

`define PORT_A 3'h0
`define PORT_B 3'h1
`define PORT_C 3'h2
`define PORT_D 3'h3
`define PORT_E 3'h4
`define NUM_PORTS 5

`define PORT_A_WIDTH 4
`define PORT_WIDTH 8

`define DIR_RST 8'hFF
`define PULL_RST 8'hFF
`define LVL_RST 8'hFF
`define ST_RST 8'hFF
`define WKEN_RST 8'h00
`define WKED_RST 8'hFF
`define PEND_RST 8'h00
`define COMP_RST 8'h00

`endif

// ===== include/port_pkg.sv
// types shared by the port configuration block
package port_pkg;

	typedef enum logic [3:0] {
		TGT_NONE,
		TGT_DIR,
		TGT_PULL,
		TGT_LVL,
		TGT_ST,
		TGT_WKEN,
		TGT_WKED,
		TGT_PEND,
		TGT_COMP
	} cfg_target_t;

	typedef struct packed {
		logic [7:0] direction;
		logic [7:0] pullup_disable;
		logic [7:0] threshold_select;
		logic [7:0] hysteresis_select;
	} port_cfg_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pullup_en;
		logic [7:0] ttl_sel;
		logic [7:0] schmitt_en;
	} port_pins_t;

	typedef struct packed {
		logic wr;
		logic [2:0] port;
		logic [7:0] data;
	} cfg_write_t;

endpackage

// ===== logic/port_cfg_bank.sv
// configuration registers of one port
`include "port_cfg.svh"

module port_cfg_bank #(
	parameter int WIDTH = 8,
	parameter bit PRESENT = 1'b1,
	parameter bit HAS_SCHMITT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire port_pkg::cfg_target_t target_i,
	input wire logic [7:0] data_i,
	output port_pkg::port_cfg_t cfg_o
);

	// bits above the port width stay at reset value, so the pin stays an input
	localparam logic [7:0] KEEP = 8'hFF << WIDTH;

	logic we;
	assign we = wr_i && PRESENT;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_o.direction <= `DIR_RST;
		end else if (we && target_i == port_pkg::TGT_DIR) begin
			cfg_o.direction <= (data_i & ~KEEP) | (`DIR_RST & KEEP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_o.pullup_disable <= `PULL_RST;
		end else if (we && target_i == port_pkg::TGT_PULL) begin
			cfg_o.pullup_disable <= (data_i & ~KEEP) | (`PULL_RST & KEEP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_o.threshold_select <= `LVL_RST;
		end else if (we && target_i == port_pkg::TGT_LVL) begin
			cfg_o.threshold_select <= (data_i & ~KEEP) | (`LVL_RST & KEEP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_o.hysteresis_select <= `ST_RST;
		end else if (we && HAS_SCHMITT && target_i == port_pkg::TGT_ST) begin
			cfg_o.hysteresis_select <= data_i;
		end
	end

endmodule

// ===== logic/port_config_mode_select.sv
// port configuration with mode selected write steering
`include "port_cfg.svh"

module port_config_mode_select #(
	parameter bit HAS_PORT_C = 1'b1,
	parameter bit HAS_PORTS_DE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_wr_i,
	input wire logic [3:0] mode_data_i,
	input wire port_pkg::cfg_write_t cfg_i,
	input wire logic [`NUM_PORTS*8-1:0] out_latch_i,
	input wire logic [7:0] port_b_pin_i,
	output logic [3:0] mode_o,
	output logic w_load_o,
	output logic [7:0] w_data_o,
	output logic [7:0] port_b_edge_pending_o,
	output logic [7:0] port_b_comparator_o,
	output logic wake_o,
	output port_pkg::port_pins_t [`NUM_PORTS-1:0] pins_o
);

	logic [3:0] mode;
	logic [7:0] port_b_wake_enable;
	logic [7:0] port_b_edge_select;
	logic [7:0] port_b_edge_pending;
	logic [7:0] port_b_comparator;
	logic [7:0] pin_prev;
	logic [7:0] edge_hit;
	logic port_b_wr;
	port_pkg::cfg_target_t target;
	port_pkg::port_cfg_t [`NUM_PORTS-1:0] cfg_q;

	function automatic port_pkg::cfg_target_t decode_target(input logic [3:0] m);
		case (m)
			`MODE_DIR: decode_target = port_pkg::TGT_DIR;
			`MODE_PULL: decode_target = port_pkg::TGT_PULL;
			`MODE_LVL: decode_target = port_pkg::TGT_LVL;
			`MODE_ST: decode_target = port_pkg::TGT_ST;
			`MODE_WKEN: decode_target = port_pkg::TGT_WKEN;
			`MODE_WKED: decode_target = port_pkg::TGT_WKED;
			`MODE_PEND: decode_target = port_pkg::TGT_PEND;
			`MODE_COMP: decode_target = port_pkg::TGT_COMP;
			default: decode_target = port_pkg::TGT_NONE;
		endcase
	endfunction

	function automatic logic port_present(input int idx);
		if (idx == `PORT_C) begin
			port_present = HAS_PORT_C;
		end else if (idx >= `PORT_D) begin
			port_present = HAS_PORTS_DE;
		end else begin
			port_present = 1'b1;
		end
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= `MODE_DIR;
		end else if (mode_wr_i) begin
			mode <= mode_data_i;
		end
	end

	assign target = decode_target(mode);
	assign port_b_wr = cfg_i.wr && cfg_i.port == `PORT_B;

	genvar p;
	generate
		for (p = 0; p < `NUM_PORTS; p++) begin : g_port
			localparam int W = (p == `PORT_A) ? `PORT_A_WIDTH : `PORT_WIDTH;
			port_cfg_bank #(
				.WIDTH(W),
				.PRESENT(port_present(p)),
				.HAS_SCHMITT(p != `PORT_A)
			) u_bank (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.wr_i(cfg_i.wr && cfg_i.port == 3'(p)),
				.target_i(target),
				.data_i(cfg_i.data),
				.cfg_o(cfg_q[p])
			);
			// pin drivers: absent ports are held as undriven inputs
			always_comb begin
				pins_o[p].out = out_latch_i[p*8 +: 8];
				pins_o[p].oe_n = port_present(p) ? cfg_q[p].direction : 8'hFF;
				// pull-up only matters while the pin listens
				pins_o[p].pullup_en = port_present(p) ?
					(~cfg_q[p].pullup_disable & cfg_q[p].direction) : 8'h00;
				pins_o[p].ttl_sel = cfg_q[p].threshold_select;
				pins_o[p].schmitt_en = ~cfg_q[p].hysteresis_select;
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_b_wake_enable <= `WKEN_RST;
		end else if (port_b_wr && target == port_pkg::TGT_WKEN) begin
			port_b_wake_enable <= cfg_i.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_b_edge_select <= `WKED_RST;
		end else if (port_b_wr && target == port_pkg::TGT_WKED) begin
			port_b_edge_select <= cfg_i.data;
		end
	end

	// edge detector; select bit 1 = falling, 0 = rising
	// sampled through reset too, so release brings no false edge
	always_ff @(posedge clk_i) begin
		pin_prev <= port_b_pin_i;
	end

	assign edge_hit = (port_b_edge_select & pin_prev & ~port_b_pin_i) |
		(~port_b_edge_select & ~pin_prev & port_b_pin_i);

	// a fresh edge beats the software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_b_edge_pending <= `PEND_RST;
		end else if (port_b_wr && target == port_pkg::TGT_PEND) begin
			port_b_edge_pending <= cfg_i.data | edge_hit;
		end else begin
			port_b_edge_pending <= port_b_edge_pending | edge_hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_b_comparator <= `COMP_RST;
		end else if (port_b_wr && target == port_pkg::TGT_COMP) begin
			port_b_comparator <= cfg_i.data;
		end
	end

	// old contents go back to the working register one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_load_o <= 1'b0;
			w_data_o <= 8'h00;
		end else begin
			w_load_o <= port_b_wr &&
				(target == port_pkg::TGT_PEND || target == port_pkg::TGT_COMP);
			if (port_b_wr && target == port_pkg::TGT_PEND) begin
				w_data_o <= port_b_edge_pending;
			end else if (port_b_wr && target == port_pkg::TGT_COMP) begin
				w_data_o <= port_b_comparator;
			end
		end
	end

	assign mode_o = mode;
	assign port_b_edge_pending_o = port_b_edge_pending;
	assign port_b_comparator_o = port_b_comparator;
	assign wake_o = |(port_b_edge_pending & port_b_wake_enable);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	mode_reset_a: assert property ($past(rst_i) |-> mode_o == `MODE_DIR)
		else $error("mode not direction after reset");

	dir_write_a: assert property (cfg_i.wr && cfg_i.port == `PORT_B
		&& target == port_pkg::TGT_DIR |=> cfg_q[1].direction == $past(cfg_i.data))
		else $error("port B direction write lost");

	pull_write_a: assert property (cfg_i.wr && cfg_i.port == `PORT_C && HAS_PORT_C
		&& target == port_pkg::TGT_PULL
		|=> cfg_q[2].pullup_disable == $past(cfg_i.data))
		else $error("port C pull-up write lost");

	pend_swap_a: assert property (port_b_wr && target == port_pkg::TGT_PEND
		|=> w_load_o && w_data_o == $past(port_b_edge_pending))
		else $error("pending swap returned wrong value");

	comp_swap_a: assert property (port_b_wr && target == port_pkg::TGT_COMP
		|=> w_data_o == $past(port_b_comparator) && port_b_comparator == $past(cfg_i.data))
		else $error("comparator swap wrong");

	oe_follow_a: assert property (port_b_wr && target == port_pkg::TGT_DIR
		|=> pins_o[1].oe_n == $past(cfg_i.data))
		else $error("port B drive not from direction");

	reset_input_a: assert property ($past(rst_i) |-> pins_o[0].oe_n == 8'hFF
		&& pins_o[1].oe_n == 8'hFF)
		else $error("pin driving after reset");

	pull_reset_a: assert property ($past(rst_i) |-> pins_o[1].pullup_en == 8'h00)
		else $error("pull-up on after reset");

	pull_output_a: assert property ((pins_o[1].pullup_en & ~pins_o[1].oe_n) == 8'h00)
		else $error("pull-up on a driven pin");

	absent_port_a: assert property (!HAS_PORTS_DE |-> pins_o[3].oe_n == 8'hFF)
		else $error("absent port driving");

	idle_mode_a: assert property (cfg_i.wr && target == port_pkg::TGT_NONE
		|=> $stable(cfg_q) && $stable(port_b_edge_select))
		else $error("unmapped mode changed configuration");

	edge_set_a: assert property (edge_hit != 8'h00 |=> (port_b_edge_pending &
		$past(edge_hit)) == $past(edge_hit))
		else $error("edge lost from pending");

endmodule

// ===== tb/pin_model.sv
// external circuitry model on the port B pins
module pin_model (
	input wire port_pkg::port_pins_t pins_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven pins show the latch, released pins follow the outside source
	assign level_o = (pins_i.out & ~pins_i.oe_n) | (ext_i & pins_i.oe_n);
endmodule

// ===== tb/port_config_mode_select_tb.sv
// self-checking bench for the port configuration block
`include "port_cfg.svh"
module port_config_mode_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [3:0] m; logic [2:0] p; logic [7:0] d; int f; logic [7:0] e;} row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, mode_wr = 1'b0, w_load, wake;
	logic [3:0] mode_data = 4'h0, mode;
	logic [39:0] latch = 40'h00_0000_0000;
	logic [7:0] ext = 8'h00, pin_b, w_data, pend, comp;
	port_pkg::cfg_write_t cfg = '0;
	port_pkg::port_pins_t [4:0] pins, pins_s;
	int num_errors = 0, checked = 0, i;
	row_t rows[9] = '{'{4'hF, 3'h1, 8'hA5, 0, 8'hA5}, '{4'hE, 3'h1, 8'h0F, 1, 8'hA0},
		'{4'hD, 3'h2, 8'h3C, 2, 8'h3C}, '{4'hC, 3'h3, 8'h0F, 3, 8'hF0},
		'{4'h7, 3'h1, 8'h00, 0, 8'hA5}, '{4'hF, 3'h0, 8'hF0, 0, 8'hF0},
		'{4'hC, 3'h0, 8'h00, 3, 8'h00}, '{4'hF, 3'h4, 8'h00, 0, 8'h00},
		'{4'hF, 3'h2, 8'h00, 0, 8'h00}};
	always #10 clk_i = ~clk_i;
	port_config_mode_select i_port_config_mode_select (.clk_i(clk_i), .rst_i(rst_i),
		.mode_wr_i(mode_wr), .mode_data_i(mode_data), .cfg_i(cfg), .out_latch_i(latch),
		.port_b_pin_i(pin_b), .mode_o(mode), .w_load_o(w_load), .w_data_o(w_data),
		.port_b_edge_pending_o(pend), .port_b_comparator_o(comp), .wake_o(wake),
		.pins_o(pins));
	// smallest variant shares the stimulus, only its pins are watched
	port_config_mode_select #(.HAS_PORT_C(1'b0), .HAS_PORTS_DE(1'b0))
		i_port_config_mode_select_small (.clk_i(clk_i), .rst_i(rst_i),
		.mode_wr_i(mode_wr), .mode_data_i(mode_data), .cfg_i(cfg), .out_latch_i(latch),
		.port_b_pin_i(pin_b), .mode_o(), .w_load_o(), .w_data_o(),
		.port_b_edge_pending_o(), .port_b_comparator_o(), .wake_o(), .pins_o(pins_s));
	pin_model i_pin_model (.pins_i(pins[1]), .ext_i(ext), .level_o(pin_b));
	function automatic logic [7:0] fld(port_pkg::port_pins_t x, int f);
		case (f)
			0: return x.oe_n;
			1: return x.pullup_en;
			2: return x.ttl_sel;
			default: return x.schmitt_en;
		endcase
	endfunction
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask
	task automatic mode_w(logic [3:0] m);
		@(negedge clk_i);
		mode_wr = 1'b1;
		mode_data = m;
		@(negedge clk_i);
		mode_wr = 1'b0;
	endtask
	task automatic cfg_w(logic [2:0] p, logic [7:0] d);
		@(negedge clk_i);
		cfg = '{1'b1, p, d};
		@(negedge clk_i);
		cfg.wr = 1'b0;
	endtask
	task automatic results;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		results();
	end
	initial begin
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		chk("mode", 8'h0F, {4'h0, mode});
		chk("oe_n", 8'hFF, pins[3].oe_n);
		chk("pullup", 8'h00, pins[2].pullup_en);
		$display("reset test done");
		// latch loaded before any pin turns output, so no glitch
		latch = 40'h00_0000_0000;
		for (i = 0; i < 9; i++) begin
			mode_w(rows[i].m);
			cfg_w(rows[i].p, rows[i].d);
			chk("row field", rows[i].e, fld(pins[rows[i].p], rows[i].f));
		end
		chk("small port c", 8'hFF, pins_s[2].oe_n);
		$display("table test done");
		mode_w(4'hB);
		cfg_w(3'h1, 8'h01);
		mode_w(4'hA);
		cfg_w(3'h1, 8'hFE);
		ext = 8'h01;
		repeat (3) @(negedge clk_i);
		chk("pending", 8'h01, pend);
		chk("wake", 8'h01, {7'h00, wake});
		mode_w(4'h9);
		cfg_w(3'h1, 8'h00);
		chk("w_load", 8'h01, {7'h00, w_load});
		chk("w_data", 8'h01, w_data);
		@(negedge clk_i);
		chk("pending clr", 8'h00, pend);
		chk("w_load end", 8'h00, {7'h00, w_load});
		mode_w(4'h8);
		cfg_w(3'h1, 8'h5A);
		chk("comp", 8'h5A, comp);
		chk("w_data", 8'h00, w_data);
		latch[15:8] = 8'hFF;
		@(negedge clk_i);
		chk("latch out", 8'hFF, pins[1].out);
		chk("pin level", 8'h5B, pin_b);
		$display("swap test done");
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk("mode rst", 8'h0F, {4'h0, mode});
		chk("oe_n rst", 8'hFF, pins[1].oe_n);
		chk("pullup rst", 8'h00, pins[1].pullup_en);
		chk("pend rst", 8'h00, pend);
		cfg_w(3'h1, 8'h00);
		chk("dir again", 8'h00, pins[1].oe_n);
		$display("mid reset test done");
		results();
	end
endmodule
